// ---- logic/pcsm_pkg.sv ----
// pcsm_pkg: address map constants and types of the config space map.
// assumes dword-indexed configuration addresses (byte address / 4).
package pcsm_pkg;
  localparam int PCSM_AW = 10;
  localparam int PCSM_DW = 32;
  localparam int PCSM_HDR_WORDS = 16;
  localparam int PCSM_EXT_NUM = 5;
  localparam logic [2:0] PCSM_EXT_MAX = 3'h3;
  // dword indices of the legacy map
  localparam logic [9:0] PCSM_HDR_LAST = 10'h00F;
  localparam logic [9:0] PCSM_PM_DW = 10'h010;
  localparam logic [9:0] PCSM_MSI_DW = 10'h012;
  localparam logic [9:0] PCSM_PCIE_DW = 10'h018;
  localparam logic [9:0] PCSM_MSIX_DW = 10'h027;
  localparam logic [9:0] PCSM_MSIX_LAST = 10'h029;
  localparam logic [9:0] PCSM_LEG_USR_FIRST = 10'h02A;
  localparam logic [9:0] PCSM_LEG_USR_LAST = 10'h03F;
  localparam logic [9:0] PCSM_HTYPE_DW = 10'h003;
  localparam logic [9:0] PCSM_ID_DW = 10'h000;
  // extended capabilities
  localparam logic [9:0] PCSM_EXT_BASE = 10'h040;
  localparam logic [9:0] PCSM_EXT_SIZE = 10'h010;
  localparam logic [3:0] PCSM_EXT_VER = 4'h1;
  // ext order: serial number, virtual channel, vendor, aer, resizable bar
  localparam logic [79:0] PCSM_EXT_IDS = 80'h0015_0001_000B_0002_0003;
  // legacy capability ids and next pointers (byte addresses)
  localparam logic [7:0] PCSM_PM_ID = 8'h01;
  localparam logic [7:0] PCSM_MSI_ID = 8'h05;
  localparam logic [7:0] PCSM_PCIE_ID = 8'h10;
  localparam logic [7:0] PCSM_MSIX_ID = 8'h11;
  localparam logic [7:0] PCSM_PM_NEXT = 8'h48;
  localparam logic [7:0] PCSM_MSI_NEXT = 8'h60;
  localparam logic [7:0] PCSM_PCIE_NEXT = 8'h9C;
  localparam logic [7:0] PCSM_HTYPE_EP = 8'h00;
  localparam logic [7:0] PCSM_HTYPE_RP = 8'h01;
  localparam logic [31:0] PCSM_ZERO = 32'h0000_0000;
  typedef enum logic [1:0] {
    PCSM_RG_HDR, PCSM_RG_CAP, PCSM_RG_RSVD, PCSM_RG_USER
  } pcsm_region_t;
  typedef enum logic [1:0] {
    PCSM_ST_IDLE, PCSM_ST_USER
  } pcsm_state_t;
endpackage : pcsm_pkg

// ---- logic/pcsm_dec_if.sv ----
// pcsm_dec_if: carries an address and the map options to the decoder.
// assumes one clock domain; the decoder is purely combinational.
`timescale 1ns/1ps
`default_nettype none
interface pcsm_dec_if;
  import pcsm_pkg::*;
  logic [PCSM_AW-1:0] addr;
  logic root_port;
  logic leg_user_en;
  logic msix_en;
  logic [PCSM_EXT_NUM-1:0] ext_en;
  logic user_ext_en;
  logic [PCSM_AW-1:0] user_ext_start;
  pcsm_region_t region;
  logic [PCSM_DW-1:0] cap_data;
  modport map (output addr, root_port, leg_user_en, msix_en, ext_en,
               user_ext_en, user_ext_start, input region, cap_data);
  modport dec (input addr, root_port, leg_user_en, msix_en, ext_en,
               user_ext_en, user_ext_start, output region, cap_data);
endinterface : pcsm_dec_if
`default_nettype wire

// ---- logic/pcsm_decode.sv ----
// pcsm_decode: classifies a config dword address into a region and
// builds the capability header dword the core answers with.
// assumes options stay stable while a request is decoded.
`timescale 1ns/1ps
`default_nettype none
module pcsm_decode
  import pcsm_pkg::*;
(
  pcsm_dec_if.dec d
);
  logic [2:0] pre [PCSM_EXT_NUM+1];
  logic [PCSM_EXT_NUM-1:0] impl;
  logic [PCSM_EXT_NUM-1:0] hit;
  logic [PCSM_DW-1:0] hdr [PCSM_EXT_NUM];
  logic [2:0] n_impl;
  logic [9:0] ext_end;
  logic [11:0] user_byte;

  assign pre[0] = 3'h0;
  // only the first three enabled structures get a slot
  assign n_impl = (pre[PCSM_EXT_NUM] > PCSM_EXT_MAX) ? PCSM_EXT_MAX
                : pre[PCSM_EXT_NUM];
  assign ext_end = PCSM_EXT_BASE + 10'(n_impl) * PCSM_EXT_SIZE;
  assign user_byte = d.user_ext_en ? {d.user_ext_start, 2'b00} : 12'h000;

  generate
    for (genvar i = 0; i < PCSM_EXT_NUM; i++) begin : g_ext
      logic [9:0] base;
      logic [11:0] nxt;
      assign pre[i+1] = pre[i] + {2'b00, d.ext_en[i]};
      assign impl[i] = d.ext_en[i] && (pre[i] < PCSM_EXT_MAX);
      assign base = PCSM_EXT_BASE + 10'(pre[i]) * PCSM_EXT_SIZE;
      assign hit[i] = impl[i] && (d.addr == base);
      // last structure chains into the user space, if any
      assign nxt = (pre[i] + 3'h1 < n_impl) ? {base + PCSM_EXT_SIZE, 2'b00}
                 : user_byte;
      assign hdr[i] = {nxt, PCSM_EXT_VER, PCSM_EXT_IDS[16*i +: 16]};
    end
  endgenerate

  always_comb begin
    d.region = PCSM_RG_RSVD;
    d.cap_data = PCSM_ZERO;
    if (d.addr <= PCSM_HDR_LAST) begin
      d.region = PCSM_RG_HDR;
    end else if (d.addr < PCSM_MSIX_DW) begin
      // capability bodies are not modelled and read as zero
      d.region = PCSM_RG_CAP;
      if (d.addr == PCSM_PM_DW) begin
        d.cap_data = {16'h0000, PCSM_PM_NEXT, PCSM_PM_ID};
      end else if (d.addr == PCSM_MSI_DW) begin
        d.cap_data = {16'h0000, PCSM_MSI_NEXT, PCSM_MSI_ID};
      end else if (d.addr == PCSM_PCIE_DW) begin
        d.cap_data = {16'h0000, d.msix_en ? PCSM_PCIE_NEXT : 8'h00,
                      PCSM_PCIE_ID};
      end
    end else if (d.addr <= PCSM_MSIX_LAST) begin
      if (d.msix_en) begin
        d.region = PCSM_RG_CAP;
        if (d.addr == PCSM_MSIX_DW) begin
          d.cap_data = {16'h0000, 8'h00, PCSM_MSIX_ID};
        end
      end else begin
        d.region = PCSM_RG_RSVD;
      end
    end else if (d.addr <= PCSM_LEG_USR_LAST) begin
      d.region = (!d.root_port && d.leg_user_en) ? PCSM_RG_USER
               : PCSM_RG_RSVD;
    end else if (d.addr < ext_end) begin
      d.region = PCSM_RG_CAP;
      for (int i = 0; i < PCSM_EXT_NUM; i++) begin
        if (hit[i]) begin
          d.cap_data = hdr[i];
        end
      end
    end else if (d.user_ext_en && d.addr >= d.user_ext_start) begin
      d.region = PCSM_RG_USER;
    end else begin
      d.region = PCSM_RG_RSVD;
    end
  end
endmodule : pcsm_decode
`default_nettype wire

// ---- logic/pcsm_map.sv ----
// pcsm_map: config space map of the express core; answers header and
// capability dwords itself, zeros reserved space, forwards user ranges.
// assumes link requests and user answers on sys_clk; options static.
`timescale 1ns/1ps
`default_nettype none
module pcsm_map
  import pcsm_pkg::*;
#(
  parameter logic [31:0] ID_CODE = 32'h0001_0001 // arbitrary value
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // map options
  input wire logic root_port,
  input wire logic leg_user_en,
  input wire logic msix_en,
  input wire logic [PCSM_EXT_NUM-1:0] ext_en,
  input wire logic user_ext_en,
  input wire logic [PCSM_AW-1:0] user_ext_start,
  // configuration requests from the link
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [PCSM_AW-1:0] req_addr,
  input wire logic req_we,
  input wire logic [PCSM_DW-1:0] req_wdata,
  // completions to the link
  output logic rsp_valid,
  output logic [PCSM_DW-1:0] rsp_data,
  // user application side
  output logic usr_req_valid,
  output logic [PCSM_AW-1:0] usr_addr,
  output logic usr_we,
  output logic [PCSM_DW-1:0] usr_wdata,
  input wire logic usr_rsp_valid,
  input wire logic [PCSM_DW-1:0] usr_rsp_data
);
  pcsm_dec_if dif ();
  pcsm_state_t state_q, state_d;
  logic ready_q, ready_d;
  logic rsp_valid_q, rsp_valid_d;
  logic [PCSM_DW-1:0] rsp_data_q, rsp_data_d;
  logic usr_valid_q, usr_valid_d;
  logic [PCSM_AW-1:0] usr_addr_q, usr_addr_d;
  logic usr_we_q, usr_we_d;
  logic [PCSM_DW-1:0] usr_wdata_q, usr_wdata_d;
  logic [PCSM_DW-1:0] hdr_q [PCSM_HDR_WORDS];
  logic [PCSM_DW-1:0] hdr_d [PCSM_HDR_WORDS];
  logic [PCSM_DW-1:0] hdr_rd;
  logic [3:0] hidx;
  logic acc;

  assign dif.addr = req_addr;
  assign dif.root_port = root_port;
  assign dif.leg_user_en = leg_user_en;
  assign dif.msix_en = msix_en;
  assign dif.ext_en = ext_en;
  assign dif.user_ext_en = user_ext_en;
  assign dif.user_ext_start = user_ext_start;

  pcsm_decode u_dec (
    .d (dif.dec)
  );

  assign acc = req_valid && ready_q && (state_q == PCSM_ST_IDLE);
  assign hidx = req_addr[3:0];

  // identity and header type are read-only overlays on the store
  always_comb begin
    hdr_rd = hdr_q[hidx];
    if (req_addr == PCSM_ID_DW) begin
      hdr_rd = ID_CODE;
    end else if (req_addr == PCSM_HTYPE_DW) begin
      hdr_rd[23:16] = root_port ? PCSM_HTYPE_RP : PCSM_HTYPE_EP;
    end
  end

  always_comb begin
    state_d = state_q;
    rsp_valid_d = 1'b0;
    rsp_data_d = rsp_data_q;
    usr_valid_d = 1'b0;
    usr_addr_d = usr_addr_q;
    usr_we_d = usr_we_q;
    usr_wdata_d = usr_wdata_q;
    hdr_d = hdr_q;
    case (state_q)
      PCSM_ST_IDLE: begin
        if (acc) begin
          if (dif.region == PCSM_RG_USER) begin
            usr_valid_d = 1'b1;
            usr_addr_d = req_addr;
            usr_we_d = req_we;
            usr_wdata_d = req_wdata;
            state_d = PCSM_ST_USER;
          end else begin
            rsp_valid_d = 1'b1;
            rsp_data_d = PCSM_ZERO;
            if (req_we) begin
              if (dif.region == PCSM_RG_HDR) begin
                hdr_d[hidx] = req_wdata;
              end
            end else if (dif.region == PCSM_RG_HDR) begin
              rsp_data_d = hdr_rd;
            end else if (dif.region == PCSM_RG_CAP) begin
              rsp_data_d = dif.cap_data;
            end
          end
        end
      end
      PCSM_ST_USER: begin
        // no timeout: a user side that never answers stalls the link
        if (usr_rsp_valid) begin
          rsp_valid_d = 1'b1;
          rsp_data_d = usr_we_q ? PCSM_ZERO : usr_rsp_data;
          state_d = PCSM_ST_IDLE;
        end
      end
      default: begin
        state_d = PCSM_ST_IDLE;
      end
    endcase
    ready_d = (state_d == PCSM_ST_IDLE);
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_q <= PCSM_ST_IDLE;
      ready_q <= 1'b0;
      rsp_valid_q <= 1'b0;
      rsp_data_q <= PCSM_ZERO;
      usr_valid_q <= 1'b0;
      usr_addr_q <= '0;
      usr_we_q <= 1'b0;
      usr_wdata_q <= PCSM_ZERO;
      for (int i = 0; i < PCSM_HDR_WORDS; i++) begin
        hdr_q[i] <= PCSM_ZERO;
      end
    end else begin
      state_q <= state_d;
      ready_q <= ready_d;
      rsp_valid_q <= rsp_valid_d;
      rsp_data_q <= rsp_data_d;
      usr_valid_q <= usr_valid_d;
      usr_addr_q <= usr_addr_d;
      usr_we_q <= usr_we_d;
      usr_wdata_q <= usr_wdata_d;
      hdr_q <= hdr_d;
    end
  end

  assign req_ready = ready_q;
  assign rsp_valid = rsp_valid_q;
  assign rsp_data = rsp_data_q;
  assign usr_req_valid = usr_valid_q;
  assign usr_addr = usr_addr_q;
  assign usr_we = usr_we_q;
  assign usr_wdata = usr_wdata_q;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  logic rd_acc;
  logic in_leg;
  assign rd_acc = acc && !req_we;
  assign in_leg = req_addr >= PCSM_LEG_USR_FIRST &&
                  req_addr <= PCSM_LEG_USR_LAST;

  hdr_type_a: assert property (rd_acc && req_addr == PCSM_HTYPE_DW |=>
    rsp_valid_q && rsp_data_q[23:16] ==
    ($past(root_port) ? PCSM_HTYPE_RP : PCSM_HTYPE_EP))
    else $error("header type does not match mode");
  leg_cap_a: assert property (rd_acc && req_addr == PCSM_PCIE_DW |=>
    rsp_data_q[7:0] == PCSM_PCIE_ID &&
    rsp_data_q[15:8] == ($past(msix_en) ? PCSM_PCIE_NEXT : 8'h00))
    else $error("express capability header wrong");
  root_leg_a: assert property (acc && in_leg && root_port |=>
    !usr_valid_q ##1 !usr_valid_q)
    else $error("root port forwarded legacy user space");
  leg_zero_a: assert property (rd_acc && in_leg && !leg_user_en |=>
    rsp_valid_q && rsp_data_q == PCSM_ZERO)
    else $error("unused legacy space not zero");
  msix_off_a: assert property (rd_acc && !msix_en &&
    req_addr >= PCSM_MSIX_DW && req_addr <= PCSM_MSIX_LAST |=>
    rsp_valid_q && rsp_data_q == PCSM_ZERO && !usr_valid_q)
    else $error("disabled msi-x space not reserved");
  ext_max_a: assert property (rd_acc && !user_ext_en &&
    req_addr == PCSM_EXT_BASE + 10'h030 |=>
    rsp_valid_q && rsp_data_q == PCSM_ZERO)
    else $error("fourth extended structure answered");
  ext_user_a: assert property (acc && user_ext_en &&
    req_addr >= user_ext_start && req_addr >= PCSM_EXT_BASE + 10'h030 |=>
    usr_valid_q && usr_addr_q == $past(req_addr) && !rsp_valid_q)
    else $error("user extended space not forwarded");
  fwd_done_a: assert property (state_q == PCSM_ST_USER && usr_rsp_valid |=>
    rsp_valid_q && state_q == PCSM_ST_IDLE && rsp_data_q ==
    ($past(usr_we_q) ? PCSM_ZERO : $past(usr_rsp_data)))
    else $error("user answer not completed");
  fwd_hold_a: assert property (usr_valid_q |-> !ready_q && !rsp_valid_q)
    else $error("link accepted while user busy");

  usr_rd_c: cover property (usr_valid_q && !usr_we_q ##[1:8] rsp_valid_q);
  ext_rd_c: cover property (rd_acc && dif.region == PCSM_RG_CAP &&
    req_addr >= PCSM_EXT_BASE);
  rsvd_rd_c: cover property (rd_acc && dif.region == PCSM_RG_RSVD);
endmodule : pcsm_map
`default_nettype wire

// ---- verification/pcsm_usr_model.sv ----
// pcsm_usr_model: user application behind the config map's user ranges.
// assumes one forwarded request at a time; answers after lag cycles.
`timescale 1ns/1ps
`default_nettype none
module pcsm_usr_model
  import pcsm_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // forwarded request
  input wire logic usr_req_valid,
  input wire logic [PCSM_AW-1:0] usr_addr,
  input wire logic usr_we,
  input wire logic [PCSM_DW-1:0] usr_wdata,
  input wire logic [3:0] lag,
  // answer
  output logic usr_rsp_valid,
  output logic [PCSM_DW-1:0] usr_rsp_data
);
  logic [PCSM_DW-1:0] mem [logic [PCSM_AW-1:0]];
  int cnt;
  always @(posedge sys_clk) begin
    usr_rsp_valid <= 1'b0;
    // data toggles between answers so a stale value never passes
    usr_rsp_data <= ~usr_rsp_data;
    if (!rst_n) begin
      cnt = 0;
      usr_rsp_data <= 32'h0;
    end else begin
      if (usr_req_valid) begin
        cnt = int'(lag) + 1;
      end
      if (cnt > 0) begin
        cnt = cnt - 1;
        if (cnt == 0) begin
          usr_rsp_valid <= 1'b1;
          if (usr_we) begin
            mem[usr_addr] = usr_wdata;
            usr_rsp_data <= 32'h0;
          end else begin
            // unimplemented user dwords read as zero
            usr_rsp_data <= mem.exists(usr_addr) ? mem[usr_addr]
                          : 32'h0;
          end
        end
      end
    end
  end
endmodule : pcsm_usr_model
`default_nettype wire

// ---- verification/test_pcsm_map.sv ----
// test_pcsm_map: self-checking bench; drives link requests, models the map.
// assumes pcsm_map and pcsm_usr_model; inputs change at falling edges.
`timescale 1ns/1ps
`default_nettype none
module test_pcsm_map;
  import pcsm_pkg::*;
  localparam logic [31:0] ID_VAL = 32'h5A5A0C0D; // arbitrary value
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic root_port = 1'b0;
  logic leg_user_en = 1'b0;
  logic msix_en = 1'b0;
  logic [4:0] ext_en = 5'h0;
  logic user_ext_en = 1'b0;
  logic [9:0] user_ext_start = 10'h070;
  logic req_valid = 1'b0;
  logic req_ready;
  logic [9:0] req_addr = 10'h0;
  logic req_we = 1'b0;
  logic [31:0] req_wdata = 32'h0;
  logic rsp_valid;
  logic [31:0] rsp_data;
  logic usr_req_valid;
  logic [9:0] usr_addr;
  logic usr_we;
  logic [31:0] usr_wdata;
  logic usr_rsp_valid;
  logic [31:0] usr_rsp_data;
  logic [3:0] lag = 4'h0;
  int n_fail = 0;
  int samples_checked = 0;
  logic [31:0] seed = 32'h9A3273B8;
  logic [31:0] bmem [logic [9:0]];
  always #5 sys_clk = ~sys_clk;
  pcsm_map #(.ID_CODE(ID_VAL)) u_pcsm_map (.sys_clk(sys_clk), .rst_n(rst_n),
    .root_port(root_port), .leg_user_en(leg_user_en), .msix_en(msix_en),
    .ext_en(ext_en), .user_ext_en(user_ext_en),
    .user_ext_start(user_ext_start), .req_valid(req_valid),
    .req_ready(req_ready), .req_addr(req_addr), .req_we(req_we),
    .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .usr_req_valid(usr_req_valid), .usr_addr(usr_addr), .usr_we(usr_we),
    .usr_wdata(usr_wdata), .usr_rsp_valid(usr_rsp_valid),
    .usr_rsp_data(usr_rsp_data));
  pcsm_usr_model u_pcsm_usr_model (.sys_clk(sys_clk), .rst_n(rst_n),
    .usr_req_valid(usr_req_valid), .usr_addr(usr_addr), .usr_we(usr_we),
    .usr_wdata(usr_wdata), .lag(lag), .usr_rsp_valid(usr_rsp_valid),
    .usr_rsp_data(usr_rsp_data));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  function automatic logic [31:0] uexp(input logic [9:0] a);
    return bmem.exists(a) ? bmem[a] : 32'h0;
  endfunction : uexp
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test
  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // called at a falling edge; request held until the edge that takes it
  task automatic acc(input logic [9:0] a, input logic w, input logic [31:0] wd,
    output logic [31:0] rd, output int lat);
    int i;
    req_addr = a;
    req_we = w;
    req_wdata = wd;
    req_valid = 1'b1;
    i = 0;
    while (req_ready !== 1'b1 && i < 100) begin
      @(negedge sys_clk);
      i++;
    end
    @(negedge sys_clk);
    req_valid = 1'b0;
    lat = 1;
    while (rsp_valid !== 1'b1 && lat < 100) begin
      @(negedge sys_clk);
      lat++;
    end
    if (i >= 100 || lat >= 100) begin
      n_fail++;
      end_of_test();
    end
    rd = rsp_data;
    // one idle edge so the next call never re-raises req_valid at once
    @(negedge sys_clk);
  endtask : acc
  task automatic rchk(input string what, input logic [9:0] a,
    input logic [31:0] m, input logic [31:0] exp, input logic core);
    logic [31:0] d;
    int l;
    acc(a, 1'b0, 32'h0, d, l);
    check(what, d & m, exp);
    // core-region completions come one cycle after the take
    if (core) check({what, " latency"}, 32'(l), 32'h1);
  endtask : rchk
  initial begin
    logic [31:0] r, d, e, q;
    logic [9:0] a, a1;
    logic [11:0] nx;
    logic [15:0] ids [3];
    int l, n;
    repeat (4) @(negedge sys_clk);
    rst_n = 1'b1;
    @(negedge sys_clk);
    for (int rp = 0; rp < 2; rp++) begin
      root_port = rp[0];
      msix_en = rp[0];
      leg_user_en = 1'b1;
      @(negedge sys_clk);
      rchk("hdr type", 10'h003, 32'h00FF0000, 32'(rp) << 16, 1);
      acc(10'h000, 1'b1, 32'hFFFFFFFF, q, l);
      check("write data", q, 32'h0);
      rchk("id", 10'h000, '1, ID_VAL, 1);
      rchk("pm", 10'h010, 32'hFFFF, 32'h4801, 1);
      rchk("msi", 10'h012, 32'hFFFF, 32'h6005, 1);
      rchk("express", 10'h018, 32'hFFFF, rp ? 32'h9C10 : 32'h10, 1);
      rchk("msix", 10'h027, rp ? 32'hFFFF : '1, rp ? 32'h11 : 0,
        1);
      for (int k = 0; k < 4; k++) begin
        r = xs();
        a = 10'h02A + 10'(r % 22);
        lag = r[31:28];
        d = xs();
        acc(a, 1'b1, d, q, l);
        if (rp == 0) bmem[a] = d;
        rchk("legacy", a, '1, rp ? 0 : uexp(a), rp[0]);
        a1 = a + 10'h1;
        rchk("legacy next", a1, '1, rp ? 0 : uexp(a1), rp[0]);
      end
    end
    root_port = 1'b0;
    leg_user_en = 1'b0;
    @(negedge sys_clk);
    rchk("legacy off", 10'h02A, '1, 32'h0, 1);
    d = xs();
    acc(10'h005, 1'b1, d, q, l);
    rchk("hdr write", 10'h005, '1, d, 1);
    for (int it = 0; it < 12; it++) begin
      r = xs();
      ext_en = (it == 0) ? 5'h1F : r[4:0];
      user_ext_en = r[5];
      lag = r[9:6];
      @(negedge sys_clk);
      n = 0;
      for (int b = 0; b < 5; b++) begin
        if (ext_en[b] && n < 3) begin
          ids[n] = PCSM_EXT_IDS[16*b +: 16];
          n++;
        end
      end
      for (int k = 0; k < 3; k++) begin
        nx = (k == n - 1) ? (user_ext_en ? {user_ext_start, 2'b00} : 12'h0)
                          : 12'(12'h100 + 12'h040 * (k + 1));
        e = (k < n) ? {nx, 4'h1, ids[k]} : 32'h0;
        rchk("extended", 10'h040 + 10'(16 * k), '1, e, 1);
      end
      if (user_ext_en) begin
        d = xs();
        if (r[10]) acc(10'h070, 1'b1, d, q, l);
        if (r[10]) bmem[10'h070] = d;
        rchk("user ext", 10'h070, '1, uexp(10'h070), 0);
      end else begin
        rchk("user ext off", 10'h070, '1, 32'h0, 1);
      end
    end
    end_of_test();
  end
endmodule : test_pcsm_map
`default_nettype wire
